/* core/tsr_defines.svh */
// Register offsets, field positions, reset values and timing figures
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH
`define TSR_ADDR_INT_INT     8'h00
`define TSR_ADDR_R1_INT      8'h01
`define TSR_ADDR_STATUS      8'h02
`define TSR_ADDR_SETUP       8'h03
`define TSR_ADDR_RATE        8'h04
`define TSR_ADDR_SETUP_ALT   8'h09
`define TSR_ADDR_RATE_ALT    8'h0a
`define TSR_ADDR_R1_FRAC     8'h10
`define TSR_ADDR_R2_INT      8'h23
`define TSR_ADDR_R2_FRAC     8'h24
`define TSR_ADDR_INT_FRAC    8'h29
`define TSR_ADDR_R3_INT      8'h2a
`define TSR_ADDR_R3_FRAC     8'h2b
`define TSR_ST_BUSY          7
`define TSR_ST_HIGH          4
`define TSR_ST_LOW           3
`define TSR_ST_FAULT         2
`define TSR_ST_CRIT          1
`define TSR_ST_HW_SHUTDOWN_FLAG          0
`define TSR_CF_MASK          7
`define TSR_CF_COMP          5
`define TSR_CF_R1_OFF        4
`define TSR_CF_R23_OFF       3
`define TSR_CF_RANGE         2
`define TSR_CF_AVG_OFF       1
`define TSR_SETUP_WMASK      8'hbe
`define TSR_SETUP_RESET      8'h00
`define TSR_RATE_WMASK       8'h0f
`define TSR_RATE_RESET       8'h06
`define TSR_RATE_FIRST_FAST  4'h5
`define TSR_RATE_LAST        4'ha
`define TSR_EXT_OFFSET       12'sh200
`define TSR_PLAIN_MAX        12'sh3ff
`define TSR_EXT_MAX          12'sh7ff
`define TSR_SHDN_BASE        8'h4d
`define TSR_SHDN_TOP         8'h70
`define TSR_STRAP_WAIT       2'h3
`define TSR_CLK_HZ           25_000_000
`endif

/* core/tsr_pkg.sv */
// Types shared by the temperature result and status block
package tsr_pkg;
   typedef enum logic {CONV_IDLE, CONV_RUN} tsr_conv_state_type;
   typedef logic [10:0] tsr_code_type;
   typedef logic signed [11:0] tsr_temp_type;
endpackage : tsr_pkg

/* core/tsr_rate_if.sv */
// Carrier between the register block and the conversion scheduler
`timescale 1ns/1ps
interface tsr_rate_if;
   logic [3:0] rate_code;
   logic       conv_start;
   logic       conv_done;
   logic       busy;
   modport ctrl  (output rate_code, output conv_done, input conv_start, input busy);
   modport timer (input rate_code, input conv_done, output conv_start, output busy);
endinterface : tsr_rate_if

/* core/tsr_rate_timer.sv */
// Conversion scheduler driven by the rate code
`timescale 1ns/1ps
`include "tsr_defines.svh"
module tsr_rate_timer
   import tsr_pkg::*;
#(
   parameter int CLK_HZ = `TSR_CLK_HZ
)(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Scheduler carrier
   tsr_rate_if.timer rif
);
   logic [31:0]        period;
   logic [31:0]        cnt_reg;
   tsr_conv_state_type state_reg;
   logic               start_reg;

   // Codes 0..4 run once a second, codes 5..A double the rate each step [RQ20]
   always_comb
   begin
      if (rif.rate_code >= `TSR_RATE_FIRST_FAST && rif.rate_code <= `TSR_RATE_LAST)
         period = 32'(CLK_HZ) >> (rif.rate_code - `TSR_RATE_FIRST_FAST + 4'h1);
      else
         period = 32'(CLK_HZ);
   end

   // A shorter period after a rate change takes effect at once [RQ19]
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         cnt_reg <= 32'h0000_0000;
      else if (cnt_reg + 32'h0000_0001 >= period)
         cnt_reg <= 32'h0000_0000;
      else
         cnt_reg <= cnt_reg + 32'h0000_0001;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg <= CONV_IDLE;
         start_reg <= 1'b0;
      end
      else
      begin
         start_reg <= 1'b0;
         unique case (state_reg)
            CONV_IDLE:
               if (cnt_reg == 32'h0000_0000)
               begin
                  state_reg <= CONV_RUN;
                  start_reg <= 1'b1;
               end
            CONV_RUN:
               if (rif.conv_done)
                  state_reg <= CONV_IDLE;
         endcase
      end
   end

   assign rif.conv_start = start_reg;
   assign rif.busy       = (state_reg == CONV_RUN); // [RQ4]

   rate_start_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ19]
      rif.conv_start |=> rif.busy)
      else $error("start did not raise busy");
endmodule : tsr_rate_timer

/* core/tsr_result_chan.sv */
// One channel result with its low-byte shadow copy
`timescale 1ns/1ps
`include "tsr_defines.svh"
module tsr_result_chan
   import tsr_pkg::*;
(
   // Clock and reset
   input wire logic         clk,
   input wire logic         rstn,
   // New measurement
   input wire logic         load,
   input wire tsr_temp_type temp,
   input wire logic         range_ext,
   // Register reads
   input wire logic         hi_rd,
   output     logic [7:0]   hi_byte,
   output     logic [7:0]   lo_byte
);
   tsr_code_type        code_reg;
   logic [2:0]          shadow_reg;
   logic signed [12:0]  shifted;

   // Extended range adds 64 degrees so code zero means minus 64 [RQ16] [RQ17]
   // Thirteen bits keep a hot reading plus the offset from wrapping negative
   always_comb
   begin
      shifted = range_ext ? 13'(temp) + 13'(`TSR_EXT_OFFSET) : 13'(temp);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         code_reg <= 11'h000;
      else if (load)
      begin
         if (shifted < 13'sh0000)
            code_reg <= 11'h000;
         else if (!range_ext && shifted > 13'(`TSR_PLAIN_MAX))
            code_reg <= 11'(`TSR_PLAIN_MAX);
         else if (shifted > 13'(`TSR_EXT_MAX))
            code_reg <= 11'(`TSR_EXT_MAX);
         else
            code_reg <= shifted[10:0]; // [RQ1]
      end
   end

   // High-byte read freezes the fraction so a pair always matches [RQ2]
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         shadow_reg <= 3'h0;
      else if (hi_rd)
         shadow_reg <= code_reg[2:0];
   end

   assign hi_byte = code_reg[10:3]; // [RQ1]
   assign lo_byte = {shadow_reg, 5'h00};

   shadow_copy_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ2]
      hi_rd |=> lo_byte[7:5] == $past(code_reg[2:0]))
      else $error("shadow fraction not latched");
endmodule : tsr_result_chan

/* core/tsr_status_core.sv */
// Result registers, status byte, setup and rate registers of the monitor
`timescale 1ns/1ps
`include "tsr_defines.svh"

// Overview of operation
// RQ1: Results are 11 bits, three fraction bits
// RQ2: High-byte read latches low-byte shadow copy
// RQ3: Status bits clear on matching status read
// RQ4: Busy bit marks conversion, never alerts
// RQ5: High-limit event sets bit 4, alerts
// RQ6: Low-limit event sets bit 3, alerts
// RQ7: Diode fault sets bit 2, alerts
// RQ8: Critical event sets bit 1, critical out
// RQ9: Strapped threshold sets bit 0, shutdown
// RQ10: Setup register reachable at both addresses
// RQ11: Unmasked setup bit 7 lets alert through
// RQ12: Mask in interrupt mode holds alert off
// RQ13: Setup bit 5 picks latched or comparator
// RQ14: Setup bit 4 disables remote1 correction
// RQ15: Setup bit 3 disables remote2/3 correction
// RQ16: Setup bit 2 selects range and format
// RQ17: Extended range encodes temperature plus 64
// RQ18: Setup bit 1 disables dynamic averaging
// RQ19: Rate register at two addresses, reset 6
// RQ20: Rate codes map to 1..64 per second
// RQ21: Unused register bits read zero
// RQ22: Host writes only rate codes 0..A
module tsr_status_core
   import tsr_pkg::*;
#(
   parameter int CLK_HZ = `TSR_CLK_HZ
)(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // Register access
   input  wire logic [7:0]   reg_addr,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   input  wire logic [7:0]   reg_wdata,
   output      logic [7:0]   reg_rdata,
   // Measurement engine
   input  wire logic         meas_valid,
   input  wire logic [1:0]   meas_chan,
   input  wire tsr_temp_type meas_temp,
   input  wire logic         conv_done,
   output      logic         conv_start,
   // Limit events and status clears
   input  wire logic         high_event,
   input  wire logic         low_event,
   input  wire logic         fault_event,
   input  wire logic         crit_event,
   input  wire logic         high_stat_clr,
   input  wire logic         low_stat_clr,
   input  wire logic         fault_stat_clr,
   input  wire logic         crit_stat_clr,
   // Shutdown strap pins
   input  wire logic [5:0]   shdn_strap,
   // Pins and analog controls
   output      logic         alert_n,
   output      logic         crit_n,
   output      logic         shutdown_out,
   output      logic         remote1_rcorr_off,
   output      logic         remote23_rcorr_off,
   output      logic         avg_disable,
   output      logic         range_ext
);
   // ----------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------
   logic [7:0] setup_reg;
   logic [7:0] rate_reg;
   logic [4:0] flag_reg;
   logic [7:0] rdata_reg;
   logic       alert_latch_reg;
   logic       alert_n_reg;
   logic       crit_n_reg;
   logic       shdn_reg;
   logic [5:0] strap_meta_reg;
   logic [5:0] strap_sync_reg;
   logic [1:0] strap_wait_reg;
   logic [7:0] shdn_limit_reg;
   logic       busy;
   logic       setup_hit;
   logic       rate_hit;
   logic       alert_req;
   logic [7:0] status_byte;
   logic [3:0] hi_rd;
   logic [7:0] hi_byte [4];
   logic [7:0] lo_byte [4];
   logic [7:0] strap_limit;
   tsr_temp_type shdn_eighths;

   tsr_rate_if rif ();

   // Either address reaches the same storage [RQ10] [RQ19]
   assign setup_hit = reg_addr == `TSR_ADDR_SETUP || reg_addr == `TSR_ADDR_SETUP_ALT;
   assign rate_hit  = reg_addr == `TSR_ADDR_RATE || reg_addr == `TSR_ADDR_RATE_ALT;

   // ----------------------------------------------------------
   // Setup and rate registers
   // ----------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         setup_reg <= `TSR_SETUP_RESET;
      else if (reg_wr && setup_hit)
         setup_reg <= reg_wdata & `TSR_SETUP_WMASK; // [RQ10] [RQ21]
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rate_reg <= `TSR_RATE_RESET; // [RQ19]
      else if (reg_wr && rate_hit)
         rate_reg <= reg_wdata & `TSR_RATE_WMASK; // [RQ21]
   end

   assign remote1_rcorr_off  = setup_reg[`TSR_CF_R1_OFF];  // [RQ14]
   assign remote23_rcorr_off = setup_reg[`TSR_CF_R23_OFF]; // [RQ15]
   assign range_ext          = setup_reg[`TSR_CF_RANGE];   // [RQ16]
   assign avg_disable        = setup_reg[`TSR_CF_AVG_OFF]; // [RQ18]

   // ----------------------------------------------------------
   // Conversion scheduling
   // ----------------------------------------------------------
   // Codes B..F are the host's to avoid; they fall back to one a second [RQ22]
   assign rif.rate_code = rate_reg[3:0];
   assign rif.conv_done = conv_done;
   assign conv_start    = rif.conv_start;
   assign busy          = rif.busy;

   tsr_rate_timer #(
      .CLK_HZ (CLK_HZ)
   ) u_timer (
      .clk  (clk),
      .rstn (rstn),
      .rif  (rif)
   );

   // ----------------------------------------------------------
   // Channel results
   // ----------------------------------------------------------
   // Channel 0 internal, 1..3 remote
   assign hi_rd[0] = reg_rd && reg_addr == `TSR_ADDR_INT_INT;
   assign hi_rd[1] = reg_rd && reg_addr == `TSR_ADDR_R1_INT;
   assign hi_rd[2] = reg_rd && reg_addr == `TSR_ADDR_R2_INT;
   assign hi_rd[3] = reg_rd && reg_addr == `TSR_ADDR_R3_INT;

   generate
      for (genvar ch = 0; ch < 4; ch++)
      begin : g_chan
         tsr_result_chan u_chan (
            .clk       (clk),
            .rstn      (rstn),
            .load      (meas_valid && meas_chan == 2'(ch)),
            .temp      (meas_temp),
            .range_ext (range_ext),
            .hi_rd     (hi_rd[ch]),
            .hi_byte   (hi_byte[ch]),
            .lo_byte   (lo_byte[ch])
         );
      end
   endgenerate

   // ----------------------------------------------------------
   // Hardware shutdown threshold
   // ----------------------------------------------------------
   // Strap pins are synchronised before use
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         strap_meta_reg <= 6'h00;
         strap_sync_reg <= 6'h00;
      end
      else
      begin
         strap_meta_reg <= shdn_strap;
         strap_sync_reg <= strap_meta_reg;
      end
   end

   // Capped so an odd strap never sets a limit above the top step
   assign strap_limit = (`TSR_SHDN_BASE + {2'h0, strap_sync_reg} > `TSR_SHDN_TOP) ?
                        `TSR_SHDN_TOP : `TSR_SHDN_BASE + {2'h0, strap_sync_reg};

   // Caught once after release, so software can never move it
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         strap_wait_reg <= 2'h0;
         shdn_limit_reg <= `TSR_SHDN_TOP;
      end
      else if (strap_wait_reg != `TSR_STRAP_WAIT)
      begin
         strap_wait_reg <= strap_wait_reg + 2'h1;
         if (strap_wait_reg + 2'h1 == `TSR_STRAP_WAIT)
            shdn_limit_reg <= strap_limit;
      end
   end

   // Limit in eighths of a degree, plain Celsius, for the raw remote 1 reading
   assign shdn_eighths = {1'b0, shdn_limit_reg, 3'h0};

   // ----------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------
   // Set wins over a clear arriving in the same cycle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         flag_reg <= 5'h00;
      else
      begin
         flag_reg[`TSR_ST_HIGH]  <= high_event ||
                                    (flag_reg[`TSR_ST_HIGH] && !high_stat_clr);   // [RQ5] [RQ3]
         flag_reg[`TSR_ST_LOW]   <= low_event ||
                                    (flag_reg[`TSR_ST_LOW] && !low_stat_clr);     // [RQ6] [RQ3]
         flag_reg[`TSR_ST_FAULT] <= fault_event ||
                                    (flag_reg[`TSR_ST_FAULT] && !fault_stat_clr); // [RQ7] [RQ3]
         flag_reg[`TSR_ST_CRIT]  <= crit_event ||
                                    (flag_reg[`TSR_ST_CRIT] && !crit_stat_clr);   // [RQ8] [RQ3]
         if (meas_valid && meas_chan == 2'h1)
            flag_reg[`TSR_ST_HW_SHUTDOWN_FLAG] <= meas_temp > shdn_eighths; // [RQ9]
      end
   end

   // Busy comes straight from the scheduler and feeds no pin [RQ4]
   assign status_byte = {busy, 2'b00, flag_reg}; // [RQ21]

   // ----------------------------------------------------------
   // Alert, critical and shutdown pins
   // ----------------------------------------------------------
   assign alert_req = flag_reg[`TSR_ST_HIGH] || flag_reg[`TSR_ST_LOW] ||
                      flag_reg[`TSR_ST_FAULT];

   // Interrupt mode latches until every alert source has cleared
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         alert_latch_reg <= 1'b0;
      else if (alert_req && !setup_reg[`TSR_CF_MASK])
         alert_latch_reg <= 1'b1; // [RQ11]
      else if (!alert_req || setup_reg[`TSR_CF_MASK])
         alert_latch_reg <= 1'b0; // [RQ12]
   end

   // Comparator mode follows the sources and ignores the mask [RQ13]
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         alert_n_reg <= 1'b1;
      else if (setup_reg[`TSR_CF_COMP])
         alert_n_reg <= !alert_req; // [RQ13]
      else
         alert_n_reg <= !((alert_latch_reg || alert_req) && !setup_reg[`TSR_CF_MASK]);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         crit_n_reg <= 1'b1;
         shdn_reg   <= 1'b0;
      end
      else
      begin
         crit_n_reg <= !flag_reg[`TSR_ST_CRIT]; // [RQ8]
         shdn_reg   <= flag_reg[`TSR_ST_HW_SHUTDOWN_FLAG];  // [RQ9]
      end
   end

   assign alert_n      = alert_n_reg;
   assign crit_n       = crit_n_reg;
   assign shutdown_out = shdn_reg;

   // ----------------------------------------------------------
   // Read data
   // ----------------------------------------------------------
   // Unmapped addresses read zero
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdata_reg <= 8'h00;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            `TSR_ADDR_INT_INT:                      rdata_reg <= hi_byte[0];
            `TSR_ADDR_R1_INT:                       rdata_reg <= hi_byte[1];
            `TSR_ADDR_R2_INT:                       rdata_reg <= hi_byte[2];
            `TSR_ADDR_R3_INT:                       rdata_reg <= hi_byte[3];
            `TSR_ADDR_INT_FRAC:                     rdata_reg <= lo_byte[0]; // [RQ2]
            `TSR_ADDR_R1_FRAC:                      rdata_reg <= lo_byte[1];
            `TSR_ADDR_R2_FRAC:                      rdata_reg <= lo_byte[2];
            `TSR_ADDR_R3_FRAC:                      rdata_reg <= lo_byte[3];
            `TSR_ADDR_STATUS:                       rdata_reg <= status_byte;
            `TSR_ADDR_SETUP, `TSR_ADDR_SETUP_ALT:   rdata_reg <= setup_reg; // [RQ10]
            `TSR_ADDR_RATE, `TSR_ADDR_RATE_ALT:     rdata_reg <= rate_reg;  // [RQ19]
            default:                                rdata_reg <= 8'h00;
         endcase
      end
   end

   assign reg_rdata = rdata_reg;

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   busy_status_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ4]
      reg_rd && reg_addr == `TSR_ADDR_STATUS |=> reg_rdata[7] == $past(busy))
      else $error("status busy bit wrong");

   busy_no_pin_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ4]
      busy && !alert_req && !alert_latch_reg && !flag_reg[`TSR_ST_CRIT] |=> alert_n && crit_n)
      else $error("busy drove a pin");

   high_set_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ5]
      high_event |=> flag_reg[`TSR_ST_HIGH])
      else $error("high flag not set");

   low_clear_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ3]
      low_stat_clr && !low_event |=> !flag_reg[`TSR_ST_LOW])
      else $error("low flag not cleared");

   fault_set_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ7]
      fault_event && fault_stat_clr |=> flag_reg[`TSR_ST_FAULT])
      else $error("fault set lost to clear");

   crit_pin_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ8]
      crit_event |=> ##1 !crit_n)
      else $error("critical pin not driven");

   shdn_pin_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ9]
      flag_reg[`TSR_ST_HW_SHUTDOWN_FLAG] |=> shutdown_out)
      else $error("shutdown pin not driven");

   setup_alias_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ10]
      reg_wr && reg_addr == `TSR_ADDR_SETUP_ALT |=>
      setup_reg == ($past(reg_wdata) & `TSR_SETUP_WMASK))
      else $error("setup alias write lost");

   mask_alert_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ12]
      setup_reg[`TSR_CF_MASK] && !setup_reg[`TSR_CF_COMP] |=> alert_n)
      else $error("masked alert asserted");

   comp_alert_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ13]
      setup_reg[`TSR_CF_COMP] && alert_req |=> !alert_n)
      else $error("comparator alert missing");

   high_alert_c: cover property (@(posedge clk) disable iff (!rstn)
      high_event ##2 !alert_n);
   shadow_pair_c: cover property (@(posedge clk) disable iff (!rstn)
      hi_rd[1] ##[1:4] reg_rd && reg_addr == `TSR_ADDR_R1_FRAC);
   shutdown_c: cover property (@(posedge clk) disable iff (!rstn)
      shutdown_out);
endmodule : tsr_status_core

/* tb/tsr_meas_model.sv */
// Measurement engine model answering each conversion round
`timescale 1ns/1ps
module tsr_meas_model
   import tsr_pkg::*;
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // Round control
   input  wire logic         conv_start,
   input  wire logic [3:0]   dly,
   input  wire tsr_temp_type temps [4],
   // Readings out
   output      logic         meas_valid,
   output      logic [1:0]   meas_chan,
   output      tsr_temp_type meas_temp,
   output      logic         conv_done
);
   // ------------------------------
   // Round sequencer
   // ------------------------------
   // Data is inverted as valid drops after each round so a stale sample never looks valid
   initial
   begin
      meas_valid = 1'b0;
      meas_chan = 2'h0;
      meas_temp = '0;
      conv_done = 1'b0;
      forever
      begin
         @(posedge clk);
         if (rstn && conv_start)
         begin
            repeat (dly) @(posedge clk);
            for (int c = 0; c < 4; c++)
            begin
               meas_valid <= 1'b1;
               meas_chan <= c[1:0];
               meas_temp <= temps[c];
               @(posedge clk);
            end
            meas_valid <= 1'b0;
            meas_temp <= ~meas_temp;
            conv_done <= 1'b1;
            @(posedge clk);
            conv_done <= 1'b0;
         end
      end
   end
endmodule : tsr_meas_model

/* tb/tsr_status_core_tb_top.sv */
// Self-checking bench for the result, status and setup registers
`timescale 1ns/1ps
module tsr_status_core_tb_top import tsr_pkg::*;;
   localparam int HZ = 640;
   localparam logic [7:0] HI [4] = '{8'h00, 8'h01, 8'h23, 8'h2a};
   localparam logic [7:0] LO [4] = '{8'h29, 8'h10, 8'h24, 8'h2b};
   logic         clk, rstn, wr, rd, mv, cs, cd, ro1, ro23, avg, rx, al_n, cr_n, sd;
   logic [7:0]   addr, wdata, rdata, d, v;
   logic [3:0]   ev, clr, dly;
   logic [5:0]   strap;
   logic [1:0]   mc;
   logic [10:0]  x;
   tsr_temp_type mt;
   tsr_temp_type temps [4];
   int           bad_count, checks, seed, i, c, n;

   tsr_status_core #(.CLK_HZ(HZ)) dut (
      .clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
      .reg_rdata(rdata), .meas_valid(mv), .meas_chan(mc), .meas_temp(mt), .conv_done(cd),
      .conv_start(cs), .high_event(ev[3]), .low_event(ev[2]), .fault_event(ev[1]),
      .crit_event(ev[0]), .high_stat_clr(clr[3]), .low_stat_clr(clr[2]),
      .fault_stat_clr(clr[1]), .crit_stat_clr(clr[0]), .shdn_strap(strap), .alert_n(al_n),
      .crit_n(cr_n), .shutdown_out(sd), .remote1_rcorr_off(ro1), .remote23_rcorr_off(ro23),
      .avg_disable(avg), .range_ext(rx));

   tsr_meas_model model (
      .clk(clk), .rstn(rstn), .conv_start(cs), .dly(dly), .temps(temps), .meas_valid(mv),
      .meas_chan(mc), .meas_temp(mt), .conv_done(cd));

   always #20 clk = ~clk;

   // ------------------------------
   // Shared tasks
   // ------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wrreg(input logic [7:0] a, input logic [7:0] w);
      @(negedge clk);
      {wr, addr, wdata} = {1'b1, a, w};
      @(negedge clk);
      wr = 1'b0;
   endtask : wrreg

   task automatic rdreg(input logic [7:0] a, output logic [7:0] q);
      @(negedge clk);
      {rd, addr} = {1'b1, a};
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      q = rdata;
   endtask : rdreg

   // Two completions guarantee one whole round after any change of inputs
   task automatic round;
      int k;
      k = 0;
      repeat (2000)
      begin
         @(negedge clk);
         if (cd === 1'b1)
            k++;
         if (k == 2)
            break;
      end
   endtask : round

   task automatic gap(output int g);
      g = 0;
      do
      begin
         @(negedge clk);
         g++;
      end
      while (cs !== 1'b1 && g < 2000);
   endtask : gap

   function automatic logic [10:0] ecode(input tsr_temp_type t, input logic ext);
      int q;
      q = ext ? int'(t) + 512 : int'(t);
      if (q < 0)
         q = 0;
      if (q > (ext ? 2047 : 1023))
         q = ext ? 2047 : 1023;
      return q[10:0];
   endfunction : ecode

   task automatic results;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   // ------------------------------
   // Main sequence
   // ------------------------------
   initial
   begin
      seed = 4984;
      clk = 1'b0;
      rstn = 1'b0;
      {wr, rd, addr, wdata, ev, clr} = '0;
      dly = 4'h1;
      strap = 6'($unsigned($random(seed)) % 36);
      foreach (temps[k])
         temps[k] = 12'sd400;
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      rdreg(8'h03, d);
      chk("setup_rst", d, 8'h00);
      rdreg(8'h0a, d);
      chk("rate_rst", d, 8'h06);
      rdreg(8'h02, d);
      chk("status_rst", d & 8'h7f, 8'h00);
      rdreg(8'h05, d);
      chk("unmapped", d, 8'h00);
      chk("pins_rst", {al_n, cr_n, sd}, 3'b110);
      for (i = 0; i < 6; i++)
      begin
         v = 8'($random(seed));
         wrreg(i[0] ? 8'h09 : 8'h03, v);
         rdreg(i[0] ? 8'h03 : 8'h09, d);
         chk("setup_alias", d, v & 8'hbe);
         chk("setup_pins", {ro1, ro23, rx, avg}, {v[4], v[3], v[2], v[1]});
         v = 8'($unsigned($random(seed)) % 11);
         wrreg(i[0] ? 8'h0a : 8'h04, v | 8'hf0);
         rdreg(i[0] ? 8'h04 : 8'h0a, d);
         chk("rate_alias", d, v);
      end
      for (i = 0; i < 11; i++)
      begin
         wrreg(8'h04, 8'(i));
         gap(n);
         gap(n);
         gap(n);
         chk("rate_gap", 16'(n), 16'(HZ / (i < 5 ? 1 : 1 << (i - 4))));
      end
      wrreg(8'h04, 8'h08);
      for (c = 0; c < 8; c++)
      begin
         wrreg(8'h03, {5'h00, c[2], 2'h0});
         temps[c[1:0]] = 12'($random(seed) % 1800);
         dly = 4'($unsigned($random(seed)) % 8);
         round;
         x = ecode(temps[c[1:0]], c[2]);
         rdreg(HI[c[1:0]], d);
         chk("result_hi", d, x[10:3]);
         rdreg(LO[c[1:0]], d);
         chk("result_lo", d, {x[2:0], 5'h00});
      end
      temps[1] = 12'sd300;
      round;
      rdreg(8'h01, d);
      temps[1] = 12'sd303;
      round;
      rdreg(8'h10, d);
      chk("shadow_old", d, 8'h80);
      rdreg(8'h01, d);
      rdreg(8'h10, d);
      chk("shadow_new", d, 8'he0);
      repeat (100)
         if (mv !== 1'b1)
            @(negedge clk);
      rdreg(8'h02, d);
      chk("busy", d[7], 1'b1);
      foreach (temps[k])
         temps[k] = 12'sd400;
      for (i = 0; i < 12; i++)
      begin
         wrreg(8'h03, i < 4 ? 8'h00 : (i < 8 ? 8'h80 : 8'ha0));
         ev = 4'h8 >> i[1:0];
         @(negedge clk);
         ev = 4'h0;
         rdreg(8'h02, d);
         chk("flag_set", d & 8'h1e, 8'h10 >> i[1:0]);
         chk("alert_on", al_n, i[1:0] == 2'd3 || (i >= 4 && i < 8));
         chk("crit_on", cr_n, i[1:0] != 2'd3);
         clr = 4'h8 >> i[1:0];
         @(negedge clk);
         clr = 4'h0;
         rdreg(8'h02, d);
         chk("flag_clr", d & 8'h1e, 8'h00);
         chk("pins_clr", {al_n, cr_n}, 2'b11);
      end
      for (i = 0; i < 2; i++)
      begin
         temps[1] = 12'((77 + strap) * 8 + 1 - i);
         round;
         rdreg(8'h02, d);
         chk("hw_shutdown_flag_flag", d[0], i == 0);
         chk("hw_shutdown_flag_pin", sd, i == 0);
      end
      results;
   end

   // Slow rate codes dominate the run, so the limit leaves them ample room
   initial
   begin
      repeat (40000) @(posedge clk);
      bad_count++;
      results;
   end
endmodule : tsr_status_core_tb_top
